// [rtl/link_host_pkg.sv]
// Shared constants for the link module handshake block.
// Assumes a single 10 MHz system clock; all counts derive from it here.
package link_host_pkg;

  localparam int CLK_HZ       = 10_000_000;
  localparam int INIT_TIME_US = 100;
  localparam int INIT_CYC     = (INIT_TIME_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int WDT_TIME_MS  = 100;
  localparam int WDT_CYC      = WDT_TIME_MS * (CLK_HZ / 1_000);
  localparam int BAUD_RATE    = 9600;
  localparam int BAUD_CYC     = CLK_HZ / BAUD_RATE;

  // Bit positions inside the 32-line window toward the controller CPU
  localparam int X_TX_DONE    = 0;
  localparam int X_RX_PEND    = 1;
  localparam int X_READY      = 7;
  localparam int X_MODE_DONE  = 9;
  localparam int X_WDT_FAULT  = 13;
  // Bit positions inside the 32-line window from the controller CPU
  localparam int Y_SEND_REQ   = 16;
  localparam int Y_RD_DONE    = 17;
  localparam int Y_MODE_REQ   = 25;

  // Operating modes
  localparam logic [2:0] MODE_DEDICATED = 3'h0;
  localparam logic [2:0] MODE_NOPROTO   = 3'h1;
  localparam logic [2:0] MODE_BIDIR     = 3'h2;

  // Register map, byte addresses
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_STATE    = 12'h004;
  localparam logic [11:0] REG_IRQ_STAT = 12'h008;
  localparam logic [11:0] REG_IRQ_MASK = 12'h00C;
  localparam logic [11:0] REG_RX_POST  = 12'h010;
  localparam logic [1:0]  BUF_SEL      = 2'h1;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WDT_EN   = 3;
  localparam int CTRL_WDT_KICK = 4;

  // Interrupt status bits
  localparam int IRQ_TX_DONE   = 0;
  localparam int IRQ_MODE_DONE = 1;
  localparam int IRQ_FAULT     = 2;
  localparam int IRQ_RX_ACK    = 3;
  localparam int IRQ_W         = 4;

  localparam logic [2:0]  MODE_RST = MODE_DEDICATED;
  localparam logic [3:0]  IRQ_RST  = 4'h0;

  typedef enum logic [2:0] {
    ST_INIT  = 3'h0,
    ST_RUN   = 3'h1,
    ST_SEND  = 3'h2,
    ST_MDONE = 3'h3,
    ST_FAULT = 3'h4
  } link_state_e;

endpackage

// [rtl/ser_if.sv]
// Word hand-off from the handshake controller to the serializer.
// Assumes both ends share the system clock.
`timescale 1ns/10ps
interface ser_if #(parameter int DATA_W = 16);
  logic [DATA_W-1:0] word;
  logic              valid;
  logic              ready;
  logic              baud_en;
  modport src (output word, output valid, output baud_en, input ready);
  modport snk (input word, input valid, input baud_en, output ready);
endinterface

// [rtl/word_serializer.sv]
// Byte-framed serializer: each word leaves LSB byte first, 8N1 per byte.
// Assumes one-cycle baud_en pulses from the controller's divider.
`timescale 1ns/10ps
module word_serializer #(
  parameter int DATA_W = 16
) (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  ser_if.snk        ser,
  output logic      serial_o
);
  localparam int NBYTE = DATA_W / 8;
  localparam int FBITS = NBYTE * 10;
  localparam int CNT_W = $clog2(FBITS + 1);

  logic [FBITS-1:0] shift_ff;
  logic [FBITS-1:0] nxt_shift;
  logic [CNT_W-1:0] left_ff;
  logic [CNT_W-1:0] nxt_left;
  logic             line_ff;
  logic             nxt_line;

  function automatic logic [FBITS-1:0] frame(input logic [DATA_W-1:0] w);
    logic [FBITS-1:0] f;
    f = '0;
    for (int i = 0; i < NBYTE; i++) begin
      f[i*10 +: 10] = {1'b1, w[i*8 +: 8], 1'b0};
    end
    return f;
  endfunction

  assign ser.ready = (left_ff == '0);
  assign serial_o  = line_ff;

  always_comb begin
    nxt_shift = shift_ff;
    nxt_left  = left_ff;
    nxt_line  = line_ff;
    if (ser.valid && ser.ready) begin
      nxt_shift = frame(ser.word);
      nxt_left  = CNT_W'(FBITS);
    end else if (ser.baud_en && left_ff != '0) begin
      nxt_line  = shift_ff[0];
      nxt_shift = shift_ff >> 1;
      nxt_left  = left_ff - 1'b1;
    end else if (ser.baud_en) begin
      nxt_line  = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      shift_ff <= '0;
      left_ff  <= '0;
      line_ff  <= 1'b1;
    end else begin
      shift_ff <= nxt_shift;
      left_ff  <= nxt_left;
      line_ff  <= nxt_line;
    end
  end
endmodule

// [rtl/link_module_host_handshake.sv]
// Handshake side of the serial link module toward the controller CPU.
// Assumes CPU request lines are synchronous to sys_clk_i.
// Contract
// RULE1: Ready rises after power-up, CPU reset, mode change.
// RULE2: Ready drops on an operation-stopping error.
// RULE3: Ready is the go-ahead for communication.
// RULE4: Mode-done rises after switch, clears on withdrawal.
// RULE5: Fault on watchdog expiry or invalid mode.
// RULE6: Fault stays low in normal operation.
// RULE7: Send request transmits buffer in raw modes.
// RULE8: CPU holds send request until transmit done.
// RULE9: CPU signals read-done after reading received data.
// RULE10: Pending drops after ack; CPU then releases.
// RULE11: Mode request reinitialises; CPU releases after done.
// RULE12: CPU never drives prohibited lines.
// RULE13: Window is 32 input and 32 output lines.
// RULE14: CPU program alone sets and clears requests.
// RULE15: Unavailable input lines stay deasserted.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
module link_module_host_handshake
  import link_host_pkg::*;
#(
  parameter int WDT_CYCLES = WDT_CYC,
  parameter int BAUD_DIV   = BAUD_CYC,
  parameter int BUF_WORDS  = 256
) (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        cpu_reset_i,
  input  wire logic [2:0]  mode_switch_i,
  input  wire logic [31:0] y_lines_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic      [31:0] x_lines_o,
  output logic             serial_tx_o,
  output logic             irq_o
);
  localparam int BUF_AW = $clog2(BUF_WORDS);
  localparam int INIT_W = $clog2(INIT_CYC + 1);
  localparam int WDT_W  = $clog2(WDT_CYCLES + 1);
  localparam int BAUD_W = $clog2(BAUD_DIV + 1);

  link_state_e       state_ff;
  link_state_e       nxt_state;
  logic [2:0]        mode_ff;
  logic [2:0]        nxt_mode;
  logic              mchg_ff;
  logic              nxt_mchg;
  logic              tx_done_ff;
  logic              nxt_tx_done;
  logic              rx_pend_ff;
  logic              nxt_rx_pend;
  logic              rd_done_prev_ff;
  logic [INIT_W-1:0] init_cnt_ff;
  logic [INIT_W-1:0] nxt_init_cnt;
  logic [WDT_W-1:0]  wdt_cnt_ff;
  logic [WDT_W-1:0]  nxt_wdt_cnt;
  logic [BUF_AW:0]   idx_ff;
  logic [BUF_AW:0]   nxt_idx;
  logic [BAUD_W-1:0] baud_cnt_ff;
  logic [BAUD_W-1:0] nxt_baud_cnt;
  logic [2:0]        ctrl_mode_ff;
  logic [2:0]        nxt_ctrl_mode;
  logic              wdt_en_ff;
  logic              nxt_wdt_en;
  logic [IRQ_W-1:0]  irq_stat_ff;
  logic [IRQ_W-1:0]  nxt_irq_stat;
  logic [IRQ_W-1:0]  irq_mask_ff;
  logic [IRQ_W-1:0]  nxt_irq_mask;
  logic [31:0]       rd_data_ff;
  logic [31:0]       nxt_rd_data;
  logic [15:0]       buf_mem [BUF_WORDS];

  logic              send_req;
  logic              rd_done_req;
  logic              mode_req;
  logic              ready;
  logic              raw_mode;
  logic              kick;
  logic              buf_wr;
  logic [BUF_AW-1:0] buf_addr;
  logic [BUF_AW:0]   send_len;
  logic [IRQ_W-1:0]  events;

  ser_if #(.DATA_W(16)) ser ();

  word_serializer #(.DATA_W(16)) u_ser (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .ser       (ser.snk),
    .serial_o  (serial_tx_o)
  );

  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // Only the documented request lines are looked at; prohibited ones are ignored  [RULE12]
  assign send_req    = y_lines_i[Y_SEND_REQ];   // [RULE13]
  assign rd_done_req = y_lines_i[Y_RD_DONE];
  assign mode_req    = y_lines_i[Y_MODE_REQ];

  assign ready    = (state_ff == ST_RUN) || (state_ff == ST_SEND) || (state_ff == ST_MDONE);
  assign raw_mode = (mode_ff == MODE_NOPROTO) || (mode_ff == MODE_BIDIR);
  assign kick     = wr_i && reg_hit(addr_i, REG_CTRL) && wdata_i[CTRL_WDT_KICK];
  assign buf_addr = addr_i[BUF_AW+1:2];
  assign buf_wr   = wr_i && (addr_i[11:10] == BUF_SEL);
  // Length word sits at the head of the buffer; clipped so the walk stays in range
  assign send_len = (buf_mem[0] > 16'(BUF_WORDS - 1)) ? (BUF_AW+1)'(BUF_WORDS - 1)
                                                      : buf_mem[0][BUF_AW:0];

  assign ser.word    = buf_mem[idx_ff[BUF_AW-1:0]];
  assign ser.valid   = (state_ff == ST_SEND) && (idx_ff <= send_len) && (idx_ff != '0);
  assign ser.baud_en = (baud_cnt_ff == '0);

  // Handshake state
  always_comb begin
    nxt_state    = state_ff;
    nxt_mode     = mode_ff;
    nxt_mchg     = mchg_ff;
    nxt_init_cnt = init_cnt_ff;
    nxt_idx      = idx_ff;
    nxt_tx_done  = tx_done_ff;
    events       = '0;
    if (cpu_reset_i) begin
      nxt_state    = ST_INIT;                                  // [RULE1]
      nxt_mchg     = 1'b0;
      nxt_init_cnt = '0;
    end else begin
      case (state_ff)
        ST_INIT: begin
          if (!mchg_ff) begin
            nxt_mode = mode_switch_i;
          end
          nxt_init_cnt = init_cnt_ff + 1'b1;
          if (init_cnt_ff == INIT_W'(INIT_CYC - 1)) begin
            nxt_init_cnt = '0;
            if (mode_ff > MODE_BIDIR) begin
              nxt_state = ST_FAULT;                            // [RULE5]
              events[IRQ_FAULT] = 1'b1;
            end else if (mchg_ff) begin
              nxt_state = ST_MDONE;                            // [RULE4]
              events[IRQ_MODE_DONE] = 1'b1;
            end else begin
              nxt_state = ST_RUN;                              // [RULE1]
            end
          end
        end
        ST_MDONE: begin
          if (!mode_req) begin
            nxt_state = ST_RUN;                                // [RULE4] [RULE11]
            nxt_mchg  = 1'b0;
          end
        end
        ST_RUN: begin
          // Dedicated mode has no raw send path, so the request is left alone there
          if (send_req && !tx_done_ff && raw_mode) begin
            nxt_state = ST_SEND;                               // [RULE7] [RULE3]
            nxt_idx   = (BUF_AW+1)'(1);
          end
        end
        ST_SEND: begin
          if (ser.valid && ser.ready) begin
            nxt_idx = idx_ff + 1'b1;
          end else if (idx_ff > send_len && ser.ready) begin
            nxt_state   = ST_RUN;
            nxt_tx_done = 1'b1;                                // [RULE7]
            events[IRQ_TX_DONE] = 1'b1;
          end
        end
        ST_FAULT: begin
          nxt_state = ST_FAULT;                                // [RULE2]
        end
        default: begin
          nxt_state = ST_INIT;
        end
      endcase
      // Mode change outranks everything but a CPU reset, including a send in flight
      if (mode_req && state_ff != ST_INIT && state_ff != ST_MDONE) begin
        nxt_state    = ST_INIT;                                // [RULE11]
        nxt_mchg     = 1'b1;
        nxt_mode     = ctrl_mode_ff;
        nxt_init_cnt = '0;
      end else if (wdt_en_ff && ready && wdt_cnt_ff == WDT_W'(WDT_CYCLES - 1)) begin
        nxt_state = ST_FAULT;                                  // [RULE5] [RULE2]
        events[IRQ_FAULT] = 1'b1;
      end
    end
    // The done flag follows the request down; a fresh completion still wins
    if (!send_req && !events[IRQ_TX_DONE]) begin
      nxt_tx_done = 1'b0;                                      // [RULE8]
    end
    if (nxt_state == ST_INIT) begin
      nxt_tx_done = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state_ff    <= ST_INIT;
      mode_ff     <= MODE_RST;
      mchg_ff     <= 1'b0;
      init_cnt_ff <= '0;
      idx_ff      <= '0;
      tx_done_ff  <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      mode_ff     <= nxt_mode;
      mchg_ff     <= nxt_mchg;
      init_cnt_ff <= nxt_init_cnt;
      idx_ff      <= nxt_idx;
      tx_done_ff  <= nxt_tx_done;
    end
  end

  // Receive pending, watchdog and baud divider
  always_comb begin
    nxt_rx_pend  = rx_pend_ff;
    nxt_wdt_cnt  = wdt_cnt_ff;
    nxt_baud_cnt = baud_cnt_ff - 1'b1;
    if (baud_cnt_ff == '0) begin
      nxt_baud_cnt = BAUD_W'(BAUD_DIV - 1);
    end
    if (rd_done_req && !rd_done_prev_ff) begin
      nxt_rx_pend = 1'b0;                                      // [RULE10] [RULE9]
    end
    if (wr_i && reg_hit(addr_i, REG_RX_POST) && wdata_i[0] && raw_mode) begin
      nxt_rx_pend = 1'b1;
    end
    if (!ready || kick || !wdt_en_ff) begin
      nxt_wdt_cnt = '0;                                        // [RULE6]
    end else begin
      nxt_wdt_cnt = wdt_cnt_ff + 1'b1;
    end
    if (state_ff == ST_INIT) begin
      nxt_rx_pend = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rx_pend_ff      <= 1'b0;
      rd_done_prev_ff <= 1'b0;
      wdt_cnt_ff      <= '0;
      baud_cnt_ff     <= '0;
    end else begin
      rx_pend_ff      <= nxt_rx_pend;
      rd_done_prev_ff <= rd_done_req;
      wdt_cnt_ff      <= nxt_wdt_cnt;
      baud_cnt_ff     <= nxt_baud_cnt;
    end
  end

  // Register file
  always_comb begin
    nxt_ctrl_mode = ctrl_mode_ff;
    nxt_wdt_en    = wdt_en_ff;
    nxt_irq_mask  = irq_mask_ff;
    nxt_irq_stat  = irq_stat_ff;
    nxt_rd_data   = '0;
    if (wr_i && reg_hit(addr_i, REG_CTRL)) begin
      nxt_ctrl_mode = wdata_i[CTRL_MODE_LSB +: 3];
      nxt_wdt_en    = wdata_i[CTRL_WDT_EN];
    end
    if (wr_i && reg_hit(addr_i, REG_IRQ_MASK)) begin
      nxt_irq_mask = wdata_i[IRQ_W-1:0];
    end
    if (wr_i && reg_hit(addr_i, REG_IRQ_STAT)) begin
      nxt_irq_stat = irq_stat_ff & ~wdata_i[IRQ_W-1:0];
    end
    // Set after clear so an event in the clearing cycle survives
    nxt_irq_stat = nxt_irq_stat | events;
    nxt_irq_stat[IRQ_RX_ACK] = nxt_irq_stat[IRQ_RX_ACK] | (rx_pend_ff && !nxt_rx_pend);
    if (rd_i) begin
      if (reg_hit(addr_i, REG_CTRL)) begin
        nxt_rd_data = {28'h000_0000, wdt_en_ff, ctrl_mode_ff};
      end else if (reg_hit(addr_i, REG_STATE)) begin
        nxt_rd_data = {22'h00_0000, state_ff, rx_pend_ff, tx_done_ff,
                       state_ff == ST_FAULT, ready, mode_ff};
      end else if (reg_hit(addr_i, REG_IRQ_STAT)) begin
        nxt_rd_data = {28'h000_0000, irq_stat_ff};
      end else if (reg_hit(addr_i, REG_IRQ_MASK)) begin
        nxt_rd_data = {28'h000_0000, irq_mask_ff};
      end else if (addr_i[11:10] == BUF_SEL) begin
        nxt_rd_data = {16'h0000, buf_mem[buf_addr]};
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ctrl_mode_ff <= MODE_RST;
      wdt_en_ff    <= 1'b0;
      irq_stat_ff  <= IRQ_RST;
      irq_mask_ff  <= IRQ_RST;
      rd_data_ff   <= '0;
    end else begin
      ctrl_mode_ff <= nxt_ctrl_mode;
      wdt_en_ff    <= nxt_wdt_en;
      irq_stat_ff  <= nxt_irq_stat;
      irq_mask_ff  <= nxt_irq_mask;
      rd_data_ff   <= nxt_rd_data;
    end
  end

  // Shared buffer has no reset, as it holds only data
  always_ff @(posedge sys_clk_i) begin
    if (buf_wr) begin
      buf_mem[buf_addr] <= wdata_i[15:0];
    end
  end

  assign rdata_o = rd_data_ff;
  assign irq_o   = |(irq_stat_ff & irq_mask_ff);

  always_comb begin
    x_lines_o              = '0;                               // [RULE15] [RULE13]
    x_lines_o[X_TX_DONE]   = tx_done_ff;
    x_lines_o[X_RX_PEND]   = rx_pend_ff;
    x_lines_o[X_READY]     = ready;                            // [RULE1] [RULE2] [RULE3]
    x_lines_o[X_MODE_DONE] = (state_ff == ST_MDONE);           // [RULE4]
    x_lines_o[X_WDT_FAULT] = (state_ff == ST_FAULT);           // [RULE5] [RULE6]
  end
endmodule

// [test/link_host_monitor.sv]
// Checker of the status and request lines at the top module's ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module link_host_monitor
  import link_host_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  input wire logic        cpu_reset_i,
  input wire logic [31:0] y_lines_i,
  input wire logic [31:0] x_lines_o,
  input wire logic        serial_tx_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  localparam logic [31:0] USED = 32'h0000_2283;

  sequence mode_taken;
    y_lines_i[Y_MODE_REQ] && x_lines_o[X_READY] && !x_lines_o[X_MODE_DONE];
  endsequence
  sequence ready_held_low;
    !x_lines_o[X_READY] [*8];
  endsequence

  unused_low_a: assert property ((x_lines_o & ~USED) == 32'h0000_0000)
    else $error("unused status line high");
  init_not_ready_a: assert property ($rose(resetn_i) |-> ready_held_low)
    else $error("ready too early after reset");
  idle_line_a: assert property ($rose(resetn_i) |-> serial_tx_o [*8])
    else $error("serial line not idle after reset");
  cpu_reset_a: assert property (cpu_reset_i |=> ready_held_low)
    else $error("ready during cpu reset init");
  mode_start_a: assert property (mode_taken |=> ready_held_low)
    else $error("mode change did not reinitialise");
  mode_release_a: assert property (x_lines_o[X_MODE_DONE] && !y_lines_i[Y_MODE_REQ]
    |=> !x_lines_o[X_MODE_DONE]) else $error("mode done not cleared");
  mode_done_ready_a: assert property ($rose(x_lines_o[X_MODE_DONE]) |-> x_lines_o[X_READY])
    else $error("mode done without ready");
  fault_ready_a: assert property (x_lines_o[X_WDT_FAULT] |-> !x_lines_o[X_READY])
    else $error("ready and fault together");
  tx_release_a: assert property (x_lines_o[X_TX_DONE] && !y_lines_i[Y_SEND_REQ]
    |=> !x_lines_o[X_TX_DONE]) else $error("transmit done not cleared");
  tx_cause_a: assert property ($rose(x_lines_o[X_TX_DONE]) |-> $past(y_lines_i[Y_SEND_REQ]))
    else $error("transmit done without request");
  ack_clear_a: assert property ($rose(y_lines_i[Y_RD_DONE]) |=> !x_lines_o[X_RX_PEND])
    else $error("pending not cleared by read done");
endmodule

// [test/cpu_model.sv]
// Controller CPU model: drives only the defined request lines.
// Assumes the module's status window and the shared system clock.
`timescale 1ns/10ps
module cpu_model
  import link_host_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic [31:0] x_lines_i,
  output logic      [31:0] y_lines_o
);
  initial y_lines_o = 32'h0000_0000;

  // Holds one request until the answering flag reaches its level or lim cycles pass, then releases
  task automatic req(input int rq, input int fl, input logic lvl, input int lim, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge sys_clk_i);
    y_lines_o[rq] <= 1'b1;
    for (n = 0; n < lim && !ok; n++) begin
      @(posedge sys_clk_i);
      ok = (x_lines_i[fl] === lvl);
    end
    y_lines_o[rq] <= 1'b0;
  endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench of the handshake block with a CPU model beside it.
// Assumes the design package; short watchdog and baud counts are used.
`timescale 1ns/10ps
module tb_top
  import link_host_pkg::*;
;
  localparam int BD = 4;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i, cpu_reset_i, wr_i, rd_i, serial_tx_o, irq_o;
  logic [2:0]  mode_switch_i;
  logic [11:0] addr_i;
  logic [31:0] wdata_i, y_lines, rdata_o, x_lines_o, got;
  logic [7:0]  rxb [4];
  bit          ok;
  int          failures = 0;
  int          cmp_count = 0;
  row_s        rows [7] = '{
    '{REG_CTRL,     32'h0000_0012, 32'h0000_0002},
    '{REG_STATE,    32'hFFFF_FFFF, 32'h0000_0088},
    '{REG_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_000F},
    '{REG_IRQ_STAT, 32'h0000_000F, 32'h0000_0000},
    '{12'h020,      32'hFFFF_FFFF, 32'h0000_0000},
    '{12'h404,      32'hABCD_1234, 32'h0000_1234},
    '{12'h7FC,      32'h0000_BEEF, 32'h0000_BEEF}};

  always #50 sys_clk_i = ~sys_clk_i;

  link_module_host_handshake #(.WDT_CYCLES(50), .BAUD_DIV(BD), .BUF_WORDS(256)) DUT (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cpu_reset_i(cpu_reset_i),
    .mode_switch_i(mode_switch_i), .y_lines_i(y_lines), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .x_lines_o(x_lines_o), .serial_tx_o(serial_tx_o), .irq_o(irq_o));
  cpu_model cpu (.sys_clk_i(sys_clk_i), .x_lines_i(x_lines_o), .y_lines_o(y_lines));

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic wait_x(input int b, input logic v, input int lim);
    int n;
    for (n = 0; n < lim && x_lines_o[b] !== v; n++) @(posedge sys_clk_i);
    chk($sformatf("wait on status %0d", b), v, x_lines_o[b]);
    if (n == lim) wrap_up();
  endtask
  // Samples mid-bit; the stop bit is checked so a framing slip shows up
  task automatic rx_byte(output logic [7:0] b);
    int n;
    for (n = 0; n < 400 && serial_tx_o !== 1'b0; n++) @(posedge sys_clk_i);
    chk("start bit", 1'b0, serial_tx_o);
    if (n == 400) wrap_up();
    repeat (BD + 1) @(posedge sys_clk_i);
    for (n = 0; n < 8; n++) begin
      b[n] = serial_tx_o;
      repeat (BD) @(posedge sys_clk_i);
    end
    chk("stop bit", 1'b1, serial_tx_o);
  endtask

  initial begin
    {resetn_i, cpu_reset_i, wr_i, rd_i} = 4'h0;
    mode_switch_i = MODE_DEDICATED;
    addr_i = 12'h000;
    wdata_i = 32'h0000_0000;
    repeat (3) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    #1 chk("status after reset", 32'h0000_0000, x_lines_o);
    chk("serial idle", 1'b1, serial_tx_o);
    chk("irq after reset", 1'b0, irq_o);
    repeat (990) @(posedge sys_clk_i);
    chk("ready during init", 1'b0, x_lines_o[X_READY]);
    wait_x(X_READY, 1'b1, 30);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, got);
      chk($sformatf("register %h", rows[i].a), rows[i].e, got);
    end
    cpu.req(Y_SEND_REQ, X_TX_DONE, 1'b1, 40, ok);
    chk("send in dedicated mode", 1'b0, ok);
    wr(REG_CTRL, {29'h0, MODE_NOPROTO});
    cpu.req(Y_MODE_REQ, X_MODE_DONE, 1'b1, 1100, ok);
    chk("mode change done", 1'b1, ok);
    if (!ok) wrap_up();
    wait_x(X_MODE_DONE, 1'b0, 4);
    chk("mode irq", 1'b1, irq_o);
    rd(REG_STATE, got);
    chk("state after mode change", 32'h0000_0089, got);
    wr(REG_IRQ_STAT, 32'h0000_0002);
    rd(REG_IRQ_STAT, got);
    chk("irq status cleared", 32'h0000_0000, got);
    chk("irq dropped", 1'b0, irq_o);
    wr(12'h400, 32'h0000_0002);
    wr(12'h404, 32'h0000_5AA5);
    wr(12'h408, 32'h0000_00FF);
    fork
      cpu.req(Y_SEND_REQ, X_TX_DONE, 1'b1, 400, ok);
      foreach (rxb[i]) rx_byte(rxb[i]);
    join
    chk("send done", 1'b1, ok);
    if (!ok) wrap_up();
    chk("sent bytes", 32'hA55A_FF00, {rxb[0], rxb[1], rxb[2], rxb[3]});
    wait_x(X_TX_DONE, 1'b0, 4);
    wr(REG_IRQ_MASK, 32'h0000_0000);
    wr(REG_IRQ_STAT, 32'h0000_000F);
    wr(REG_RX_POST, 32'h0000_0001);
    rd(REG_STATE, got);
    chk("receive pending", 32'h0000_00C9, got);
    cpu.req(Y_RD_DONE, X_RX_PEND, 1'b0, 10, ok);
    chk("read done handshake", 1'b1, ok);
    if (!ok) wrap_up();
    rd(REG_IRQ_STAT, got);
    chk("ack status", 32'h0000_0008, got);
    chk("masked irq", 1'b0, irq_o);
    wr(REG_IRQ_STAT, 32'h0000_000F);
    wr(REG_IRQ_MASK, 32'h0000_000F);
    wr(REG_CTRL, 32'h0000_0009);
    repeat (4) begin
      repeat (30) @(posedge sys_clk_i);
      wr(REG_CTRL, 32'h0000_0019);
    end
    chk("no fault while kicked", 1'b0, x_lines_o[X_WDT_FAULT]);
    wait_x(X_WDT_FAULT, 1'b1, 80);
    chk("ready on fault", 1'b0, x_lines_o[X_READY]);
    chk("fault irq", 1'b1, irq_o);
    wr(REG_CTRL, {29'h0, MODE_BIDIR});
    cpu.req(Y_MODE_REQ, X_MODE_DONE, 1'b1, 1100, ok);
    chk("recovery by mode change", 1'b1, ok);
    if (!ok) wrap_up();
    chk("fault cleared", 1'b0, x_lines_o[X_WDT_FAULT]);
    mode_switch_i <= 3'h5;
    cpu_reset_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    cpu_reset_i <= 1'b0;
    wait_x(X_WDT_FAULT, 1'b1, 1100);
    chk("ready with bad switch", 1'b0, x_lines_o[X_READY]);
    wrap_up();
  end
endmodule

bind link_module_host_handshake link_host_monitor MON (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cpu_reset_i(cpu_reset_i),
  .y_lines_i(y_lines_i), .x_lines_o(x_lines_o), .serial_tx_o(serial_tx_o));
